/* hrds_pkg.sv */
// constants and carrier types for the receive descriptor status write-back
// assumes a 16-bit status word with field 0 at the top bit
package hrds_pkg;
   localparam int STAT_W = 16;
   localparam int LEN_W = 16;
   localparam int IDX_W = 8;
   localparam int ADDR_W = 32;
   // status bit positions (field n sits at bit 15-n)
   localparam int B_EMPTY = 15;
   localparam int B_WRAP = 13;
   localparam int B_INTREQ = 12;
   localparam int B_LAST = 11;
   localparam int B_FIRST = 10;
   localparam int B_CONT = 9;
   localparam int B_SWTAG = 7;
   localparam int B_LENVIOL = 5;
   localparam int B_ABORT = 3;
   localparam int B_CARRIER = 1;
   localparam int B_OVERRUN = 0;
   // descriptor is 8 bytes, data words are 4 bytes
   localparam logic [2:0] DESC_SHIFT = 3'h3;
   localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
   localparam logic [16:0] LWORD_ROUND = 17'h0_0003;
   localparam logic [16:0] LWORD_MASK = 17'h1_FFFC;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
   localparam logic [IDX_W-1:0] IDX_FIRST = 8'h00;
   localparam logic [IDX_W-1:0] IDX_ONE = 8'h01;
   localparam logic [1:0] PACK_LAST = 2'h3;
   localparam logic [STAT_W-1:0] WB_MASK = 16'h8C2B;
   localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;

   typedef struct packed {
      logic [STAT_W-1:0] stat;
      logic [LEN_W-1:0] len;
      logic [ADDR_W-1:0] ptr;
   } hrds_desc_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [STAT_W-1:0] stat;
      logic [STAT_W-1:0] mask;
      logic [LEN_W-1:0] len;
   } hrds_wb_t;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b000,
      ST_RECV = 3'b001,
      ST_FLUSH = 3'b010,
      ST_DRAIN = 3'b011,
      ST_WB = 3'b100
   } hrds_state_t;
endpackage

/* hrds_word_pack.sv */
// byte to longword packer, first byte in the top lane
// assumes byteValid and flush never arrive in the same cycle
`timescale 1ns/1ps
module hrds_word_pack
   import hrds_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic byteValid, // one byte to pack
   input wire logic [7:0] byteData, // byte value
   input wire logic flush, // emit a partial word
   output logic wordValid, // one-cycle word strobe
   output logic [31:0] wordData // packed word
);
   logic [31:0] acc_r;
   logic [1:0] cnt_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         acc_r <= 32'h0000_0000;
         cnt_r <= 2'h0;
         wordValid <= 1'b0;
         wordData <= 32'h0000_0000;
      end else begin
         wordValid <= 1'b0;
         if (byteValid) begin
            if (cnt_r == PACK_LAST) begin
               wordValid <= 1'b1;
               wordData <= {acc_r[31:8], byteData};
               acc_r <= 32'h0000_0000;
            end else begin
               acc_r[(3 - cnt_r) * 8 +: 8] <= byteData;
            end
            cnt_r <= cnt_r + 2'h1;
         end else if (flush && cnt_r != 2'h0) begin
            wordValid <= 1'b1;
            wordData <= acc_r;
            acc_r <= 32'h0000_0000;
            cnt_r <= 2'h0;
         end
      end
   end
endmodule // hrds_word_pack

/* hrds_rx_status.sv */
// receive descriptor walk, data write and status write-back for one channel
// assumes bytes, flags and errors come from deframing logic on mclk
// Operation
// - interrupt-request clear: no buffer flag after use; frame flag unaffected
// - interrupt-request set: buffer flag, and frame flag in hdlc, posted
// - hdlc: last-in-frame on closing flag or error, error bit set
// - last buffer closes with frame octet count in length field
// - first-in-frame only on the buffer receiving the frame start
// - continuous mode keeps empty set after close
// - continuous mode keeps empty set even on an error close
// - software tag bit is never written by the controller
// - over-length frame: only max length rounded up to longword stored
// - aligned max: violation seen once byte count exceeds it
// - unaligned max: violation seen at the next longword write
// - violation seen within three byte times
// - after violation keep receiving, discard excess bytes
// - violation: close at next flag with length-violation bit
// - violation length counts every byte between the flags
// - close clears empty unless continuous; non-empty descriptor not used
// - wrap bit returns to first descriptor at table base
// - length field written once, at close
`timescale 1ns/1ps
module hrds_rx_status
   import hrds_pkg::*;
(
   input wire logic mclk, // system clock, 100 MHz
   input wire logic nrst, // async reset, active low
   input wire logic hdlcMode, // 1 hdlc, 0 transparent
   input wire logic [ADDR_W-1:0] rxTableBase, // descriptor table base
   input wire logic [LEN_W-1:0] maxFrameLen, // max frame length in bytes
   input wire logic [LEN_W-1:0] bufLen, // buffer size, multiple of 4
   input wire logic rxByteValid, // received byte strobe
   input wire logic [7:0] rxByte, // received byte
   input wire logic rxFlag, // flag seen on the line
   input wire logic rxCarrierLost, // carrier lost pulse
   input wire logic rxOverrun, // overrun pulse
   input wire logic rxAbort, // abort seen pulse
   output logic rxReady, // bytes and events accepted
   output logic descReq, // descriptor read request
   output logic [ADDR_W-1:0] descAddr, // descriptor address
   input wire logic descAck, // read answer strobe
   input wire hrds_pkg::hrds_desc_t descRd, // descriptor read data
   output logic descWr, // status write-back strobe
   output hrds_pkg::hrds_wb_t descWb, // write-back address, bits, mask, length
   output logic memWr, // data word write strobe
   output logic [ADDR_W-1:0] memWrAddr, // data word address
   output logic [31:0] memWrData, // data word
   output logic bufRecvFlag, // buffer-received flag post
   output logic frameRecvFlag // frame-received flag post
);
   hrds_state_t state_r;
   hrds_desc_t curDesc_r;
   logic [IDX_W-1:0] descIdx_r;
   logic [LEN_W-1:0] frameCnt_r, bufCnt_r;
   logic [ADDR_W-1:0] wordOff_r;
   logic inFrame_r, lenViol_r, bufFirst_r, flush_r;
   logic closeLast_r, errCarrier_r, errOverrun_r, errAbort_r;
   logic byteAcc, discard, pkValid, bufFull, errEv, endEv, fetchOk;
   logic pkWordValid;
   logic [31:0] pkWordData;
   logic [16:0] lenLimit;

   assign lenLimit = ({1'b0, maxFrameLen} + LWORD_ROUND) & LWORD_MASK;
   assign byteAcc = rxByteValid && rxReady;
   // bytes past the rounded limit are counted but not stored
   assign discard = hdlcMode && inFrame_r && ({1'b0, frameCnt_r} >= lenLimit);
   assign pkValid = byteAcc && !discard;
   assign bufFull = pkValid && (bufCnt_r + LEN_ONE == bufLen);
   assign errEv = rxCarrierLost || rxOverrun || rxAbort;
   assign endEv = rxReady && hdlcMode && inFrame_r && (rxFlag || errEv);
   assign fetchOk = descReq && descAck && descRd.stat[B_EMPTY];

   hrds_word_pack u_pack (
      .mclk(mclk),
      .nrst(nrst),
      .byteValid(pkValid),
      .byteData(rxByte),
      .flush(flush_r),
      .wordValid(pkWordValid),
      .wordData(pkWordData)
   );

   // descriptor walk and close sequence
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_FETCH;
         descReq <= 1'b1;
         rxReady <= 1'b0;
         flush_r <= 1'b0;
         closeLast_r <= 1'b0;
         errCarrier_r <= 1'b0;
         errOverrun_r <= 1'b0;
         errAbort_r <= 1'b0;
         descIdx_r <= IDX_FIRST;
         curDesc_r <= '0;
      end else begin
         flush_r <= 1'b0;
         case (state_r)
            ST_FETCH: begin
               descReq <= !(descReq && descAck);
               if (descReq && descAck) begin
                  curDesc_r <= descRd;
                  if (fetchOk) begin
                     state_r <= ST_RECV;
                     rxReady <= 1'b1;
                  end
               end
            end
            ST_RECV: begin
               if (endEv) begin
                  closeLast_r <= 1'b1;
                  errCarrier_r <= rxCarrierLost;
                  errOverrun_r <= rxOverrun;
                  errAbort_r <= rxAbort;
                  flush_r <= 1'b1;
                  rxReady <= 1'b0;
                  state_r <= ST_FLUSH;
               end else if (bufFull) begin
                  closeLast_r <= 1'b0;
                  errCarrier_r <= 1'b0;
                  errOverrun_r <= 1'b0;
                  errAbort_r <= 1'b0;
                  flush_r <= 1'b1;
                  rxReady <= 1'b0;
                  state_r <= ST_FLUSH;
               end
            end
            ST_FLUSH: state_r <= ST_DRAIN;
            ST_DRAIN: state_r <= ST_WB;
            ST_WB: begin
               descIdx_r <= curDesc_r.stat[B_WRAP] ? IDX_FIRST : descIdx_r + IDX_ONE;
               descReq <= 1'b1;
               state_r <= ST_FETCH;
            end
            default: begin
               state_r <= ST_FETCH;
               descReq <= 1'b1;
               rxReady <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         descAddr <= 32'h0000_0000;
      end else begin
         descAddr <= rxTableBase + {21'h0, descIdx_r, DESC_SHIFT'(0)};
      end
   end

   // frame byte count, first-byte and length-violation tracking
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frameCnt_r <= 16'h0000;
         inFrame_r <= 1'b0;
         lenViol_r <= 1'b0;
      end else begin
         if (byteAcc && !inFrame_r) begin
            frameCnt_r <= LEN_ONE;
            inFrame_r <= 1'b1;
            lenViol_r <= 1'b0;
         end else if (byteAcc) begin
            frameCnt_r <= frameCnt_r + LEN_ONE;
            if (discard)
               lenViol_r <= 1'b1;
         end
         if (state_r == ST_WB && closeLast_r)
            inFrame_r <= 1'b0;
      end
   end

   // per-buffer byte count and first-in-frame mark
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bufCnt_r <= 16'h0000;
         bufFirst_r <= 1'b0;
      end else if (fetchOk) begin
         bufCnt_r <= 16'h0000;
         bufFirst_r <= 1'b0;
      end else begin
         if (pkValid)
            bufCnt_r <= bufCnt_r + LEN_ONE;
         if (byteAcc && !inFrame_r)
            bufFirst_r <= 1'b1;
      end
   end

   // data words into the current buffer
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         memWr <= 1'b0;
         memWrAddr <= 32'h0000_0000;
         memWrData <= 32'h0000_0000;
         wordOff_r <= 32'h0000_0000;
      end else begin
         memWr <= pkWordValid;
         if (fetchOk) begin
            wordOff_r <= 32'h0000_0000;
         end else if (pkWordValid) begin
            memWrAddr <= curDesc_r.ptr + wordOff_r;
            memWrData <= pkWordData;
            wordOff_r <= wordOff_r + WORD_STEP;
         end
      end
   end

   // status write-back and interrupt table posts
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         descWr <= 1'b0;
         descWb <= '0;
         bufRecvFlag <= 1'b0;
         frameRecvFlag <= 1'b0;
      end else begin
         descWr <= (state_r == ST_WB);
         bufRecvFlag <= (state_r == ST_WB) && curDesc_r.stat[B_INTREQ];
         frameRecvFlag <= (state_r == ST_WB) && closeLast_r && hdlcMode;
         if (state_r == ST_WB) begin
            descWb.addr <= descAddr;
            descWb.mask <= WB_MASK;
            descWb.stat <= STAT_RST;
            descWb.stat[B_EMPTY] <= curDesc_r.stat[B_CONT];
            descWb.stat[B_LAST] <= closeLast_r && hdlcMode;
            descWb.stat[B_FIRST] <= bufFirst_r;
            descWb.stat[B_LENVIOL] <= closeLast_r && lenViol_r;
            descWb.stat[B_ABORT] <= errAbort_r;
            descWb.stat[B_CARRIER] <= errCarrier_r;
            descWb.stat[B_OVERRUN] <= errOverrun_r;
            descWb.len <= closeLast_r ? frameCnt_r : bufCnt_r;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_bufflag_gated: assert property (descWr && !curDesc_r.stat[B_INTREQ] |-> !bufRecvFlag)
      else $error("buffer flag posted with interrupt request clear");
   a_bufflag_posted: assert property (descWr && curDesc_r.stat[B_INTREQ] |-> bufRecvFlag)
      else $error("buffer flag missing with interrupt request set");
   a_frameflag_last: assert property (frameRecvFlag |-> descWr && descWb.stat[B_LAST])
      else $error("frame flag without last-in-frame close");
   a_last_len: assert property (descWr && descWb.stat[B_LAST] |-> descWb.len == frameCnt_r)
      else $error("last buffer length differs from frame count");
   a_err_last: assert property (state_r == ST_RECV && endEv && errEv
      |-> ##4 descWr && descWb.stat[B_LAST])
      else $error("error did not close a last-in-frame buffer");
   a_empty_cont: assert property (descWr |-> descWb.stat[B_EMPTY] == curDesc_r.stat[B_CONT])
      else $error("empty bit does not follow continuous mode");
   a_tag_untouched: assert property (descWr |-> !descWb.mask[B_SWTAG] && !descWb.mask[B_CONT])
      else $error("write-back touches tag or continuous bit");
   a_wrap_index: assert property (descWr && curDesc_r.stat[B_WRAP] |-> descIdx_r == IDX_FIRST)
      else $error("wrap did not return to first descriptor");
   a_discard_excess: assert property (byteAcc && discard |-> !pkValid ##1 !u_pack.wordValid)
      else $error("excess byte stored after limit");
   a_viol_latency: assert property (byteAcc && hdlcMode && inFrame_r
      && {1'b0, frameCnt_r} >= {1'b0, maxFrameLen} + LWORD_ROUND |=> lenViol_r)
      else $error("length violation not seen within three bytes");
   a_len_once: assert property (descWr |=> !descWr)
      else $error("length field written twice");
   a_no_reuse: assert property (descReq && descAck && !descRd.stat[B_EMPTY] |=> state_r == ST_FETCH)
      else $error("non-empty descriptor taken");

   c_len_viol: cover property (descWr && descWb.stat[B_LENVIOL]);
   c_cont_close: cover property (descWr && descWb.stat[B_EMPTY]);
   c_single_buf: cover property (descWr && descWb.stat[B_FIRST] && descWb.stat[B_LAST]);
   c_wrap: cover property (descWr && curDesc_r.stat[B_WRAP]);
endmodule // hrds_rx_status

/* hrds_host_model.sv */
// host side model: four-entry descriptor table with masked write-back
// assumes the table sits at base and answers after dly idle cycles
`timescale 1ns/1ps
module hrds_host_model
   import hrds_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [31:0] base, // table base
   input wire logic [3:0] dly, // answer delay in cycles
   input wire logic descReq, // read request
   input wire logic [31:0] descAddr, // read address
   output logic descAck, // read answer
   output hrds_pkg::hrds_desc_t descRd, // read data
   input wire logic descWr, // write-back strobe
   input wire hrds_pkg::hrds_wb_t descWb // write-back content
);
   hrds_desc_t tbl [4];
   logic [3:0] cnt;
   logic [1:0] rIdx;
   logic [1:0] wIdx;
   assign rIdx = 2'((descAddr - base) >> 3);
   assign wIdx = 2'((descWb.addr - base) >> 3);
   // read data only valid in the answer cycle
   assign descRd = descAck ? tbl[rIdx] : hrds_desc_t'(~tbl[rIdx]);
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         descAck <= 1'b0;
         cnt <= 4'h0;
      end else if (descReq && !descAck && cnt >= dly) begin
         descAck <= 1'b1;
         cnt <= 4'h0;
      end else begin
         descAck <= 1'b0;
         cnt <= (descReq && !descAck) ? cnt + 4'h1 : 4'h0;
      end
   end
   // continuous mode stays until software itself clears it
   always @(posedge mclk) begin
      if (descWr) begin
         tbl[wIdx].stat <= (tbl[wIdx].stat & ~descWb.mask) | (descWb.stat & descWb.mask);
         tbl[wIdx].len <= descWb.len;
      end
   end
endmodule // hrds_host_model

/* hrds_rx_status_bench.sv */
// self-checking bench for the receive status write-back
// assumes hdlc mode except in the transparent case, 16-byte buffers and the host model above
`timescale 1ns/1ps
module hrds_rx_status_bench;
   import hrds_pkg::*;
   localparam logic [31:0] BASE = 32'h0000_1000;
   logic mclk, nrst, hdlcMode, rxByteValid, rxFlag, rxCarrierLost, rxOverrun, rxAbort;
   logic rxReady, descReq, descAck, descWr, memWr, bufRecvFlag, frameRecvFlag;
   logic [15:0] maxFrameLen, bufLen;
   logic [7:0] rxByte;
   logic [3:0] dly;
   logic [31:0] descAddr, memWrAddr, memWrData;
   hrds_desc_t descRd;
   hrds_wb_t descWb;
   hrds_wb_t wbQ[$];
   logic [1:0] flQ[$];
   logic [31:0] mwQ[$];
   logic [31:0] maQ[$];
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   hrds_rx_status u_dut (.mclk(mclk), .nrst(nrst), .hdlcMode(hdlcMode), .rxTableBase(BASE),
      .maxFrameLen(maxFrameLen), .bufLen(bufLen), .rxByteValid(rxByteValid), .rxByte(rxByte),
      .rxFlag(rxFlag), .rxCarrierLost(rxCarrierLost), .rxOverrun(rxOverrun), .rxAbort(rxAbort),
      .rxReady(rxReady), .descReq(descReq), .descAddr(descAddr), .descAck(descAck),
      .descRd(descRd), .descWr(descWr), .descWb(descWb), .memWr(memWr), .memWrAddr(memWrAddr),
      .memWrData(memWrData), .bufRecvFlag(bufRecvFlag), .frameRecvFlag(frameRecvFlag));
   hrds_host_model u_host (.mclk(mclk), .nrst(nrst), .base(BASE), .dly(dly), .descReq(descReq),
      .descAddr(descAddr), .descAck(descAck), .descRd(descRd), .descWr(descWr), .descWb(descWb));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (descWr) begin
         wbQ.push_back(descWb);
         flQ.push_back({bufRecvFlag, frameRecvFlag});
      end
      if (memWr) begin
         mwQ.push_back(memWrData);
         maQ.push_back(memWrAddr);
      end
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   function logic [15:0] bt(input int b);
      bt = 16'h0001 << b;
   endfunction
   function hrds_desc_t mk(input logic [15:0] st, input int i);
      mk = '{stat: st, len: 16'h0000, ptr: 32'h0000_2000 + (32'(i) << 8)};
   endfunction
   task chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task sendBytes(input int n);
      int k;
      int t;
      k = 0;
      t = 0;
      while (k < n && t < 400) begin
         @(negedge mclk);
         rxByteValid = (rxReady === 1'b1);
         rxByte = 8'(k);
         if (rxReady === 1'b1) k++;
         t++;
      end
      chk(k == n, "bytes not taken");
   endtask
   // one-hot end event: overrun, carrier, abort, flag
   task endEv(input logic [3:0] ev);
      int t;
      t = 0;
      @(negedge mclk);
      rxByteValid = 1'b0;
      while (rxReady !== 1'b1 && t < 300) begin
         @(negedge mclk);
         t++;
      end
      chk(rxReady === 1'b1, "receiver not ready for end event");
      {rxOverrun, rxCarrierLost, rxAbort, rxFlag} = ev;
      @(negedge mclk);
      {rxOverrun, rxCarrierLost, rxAbort, rxFlag} = 4'h0;
   endtask
   task waitWb(input int n);
      int t;
      t = 0;
      while (wbQ.size() < n && t < 300) begin
         @(negedge mclk);
         t++;
      end
      chk(wbQ.size() == n, "write-back count");
   endtask
   task chkWb(input logic [15:0] on, input logic [15:0] off, input logic [15:0] len,
      input logic [1:0] fl);
      hrds_wb_t w;
      w = wbQ.pop_front();
      chk((w.stat & w.mask & on) === on, "status bit not set");
      chk((~w.stat & w.mask & off) === off, "status bit not cleared");
      chk(w.mask[B_SWTAG] === 1'b0, "tag bit written");
      chk(w.len === len, "length field");
      chk(flQ.pop_front() === fl, "flag posting");
   endtask
   task s_single();
      sendBytes(4);
      endEv(4'h1);
      waitWb(1);
      chkWb(bt(B_FIRST) | bt(B_LAST), bt(B_EMPTY), 16'h0004, 2'h3);
      chk(mwQ.pop_front() === 32'h0001_0203, "data word");
      chk(maQ.pop_front() === 32'h0000_2000, "data address");
   endtask
   task s_multi();
      int t;
      sendBytes(20);
      endEv(4'h1);
      waitWb(2);
      chkWb(bt(B_FIRST), bt(B_LAST) | bt(B_EMPTY), 16'h0010, 2'h0);
      chkWb(bt(B_LAST), bt(B_FIRST) | bt(B_EMPTY), 16'h0014, 2'h3);
      chk(mwQ.size() == 5 && mwQ[4] === 32'h1011_1213, "frame data");
      chk(maQ[3] === 32'h0000_210C && maQ[4] === 32'h0000_2200, "data addresses");
      mwQ.delete();
      maQ.delete();
      t = 0;
      while (descReq !== 1'b1 && t < 50) begin
         @(negedge mclk);
         t++;
      end
      chk(descReq === 1'b1 && descAddr === BASE, "wrap to table base");
   endtask
   task s_cont();
      int eb;
      repeat (20) @(negedge mclk);
      chk(rxReady === 1'b0, "closed descriptor used");
      dly = 4'h3;
      u_host.tbl[1] = mk(bt(B_EMPTY) | bt(B_CONT), 1);
      u_host.tbl[2] = mk(bt(B_EMPTY) | bt(B_CONT), 2);
      u_host.tbl[0] = mk(bt(B_EMPTY) | bt(B_CONT), 0);
      for (int k = 1; k < 4; k++) begin
         eb = (k == 1) ? B_ABORT : (k == 2) ? B_CARRIER : B_OVERRUN;
         sendBytes(3);
         endEv(4'h1 << k);
         waitWb(1);
         chkWb(bt(B_FIRST) | bt(B_LAST) | bt(eb), 16'h0000, 16'h0003, 2'h1);
         chk(u_host.tbl[k - 1].stat[B_EMPTY] === 1'b1, "empty cleared");
         chk(u_host.tbl[k - 1].stat[B_CONT] === 1'b1, "continuous bit lost");
         chk(mwQ.pop_front() === 32'h0001_0200, "padded word");
      end
   endtask
   task s_lenviol();
      dly = 4'h5;
      u_host.tbl[3] = mk(bt(B_EMPTY) | bt(B_INTREQ), 3);
      u_host.tbl[0] = mk(bt(B_EMPTY) | bt(B_INTREQ) | bt(B_WRAP), 0);
      mwQ.delete();
      for (int k = 0; k < 2; k++) begin
         @(negedge mclk);
         maxFrameLen = (k == 1) ? 16'h0008 : 16'h0006;
         sendBytes((k == 1) ? 9 : 12);
         endEv(4'h1);
         waitWb(1);
         chkWb(bt(B_LAST) | bt(B_LENVIOL), bt(B_EMPTY), (k == 1) ? 16'h0009 : 16'h000C,
            2'h3);
         chk(mwQ.size() == 2, "excess bytes stored");
         mwQ.delete();
      end
   endtask
   // transparent: flag ignored, buffer closes only when full, no last bit
   task s_transp();
      @(negedge mclk);
      hdlcMode = 1'b0;
      u_host.tbl[0] = mk(bt(B_EMPTY) | bt(B_INTREQ), 0);
      sendBytes(8);
      endEv(4'h1);
      sendBytes(8);
      waitWb(1);
      chkWb(bt(B_FIRST), bt(B_LAST) | bt(B_EMPTY), 16'h0010, 2'h2);
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      hdlcMode = 1'b1;
      maxFrameLen = 16'h0100;
      bufLen = 16'h0010;
      {rxByteValid, rxFlag, rxCarrierLost, rxOverrun, rxAbort} = 5'h00;
      rxByte = 8'h00;
      dly = 4'h0;
      u_host.tbl[0] = mk(bt(B_EMPTY) | bt(B_INTREQ) | bt(B_SWTAG), 0);
      u_host.tbl[1] = mk(bt(B_EMPTY), 1);
      u_host.tbl[2] = mk(bt(B_EMPTY) | bt(B_INTREQ) | bt(B_WRAP), 2);
      u_host.tbl[3] = mk(16'h0000, 3);
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      s_single();
      s_multi();
      s_cont();
      s_lenviol();
      s_transp();
      tally_and_finish();
   end
endmodule // hrds_rx_status_bench
